// ===== design/pgpio_pkg.sv
// Purpose: Constants for the two-port general I/O block
// Assumes: Byte-wide register port, one register per index
// Notes: Register offsets are local choices

package pgpio_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_P1_DIR = 4'h0;
  localparam logic [3:0] ADDR_P1_DATA = 4'h1;
  localparam logic [3:0] ADDR_P1_PULLUP = 4'h2;
  localparam logic [3:0] ADDR_P2_DIR = 4'h3;
  localparam logic [3:0] ADDR_P2_DATA = 4'h4;
  localparam logic [3:0] ADDR_FUNC_SEL = 4'h5;

  // ==========================================================
  // Implemented bits and read-as-one masks
  localparam logic [7:0] P1_IMPL_MASK = 8'hF7;
  localparam logic [7:0] P1_RSVD_ONES = 8'h08;
  localparam logic [2:0] P2_IMPL_MASK = 3'h7;
  localparam logic [7:0] P2_RSVD_ONES = 8'hF8;
  localparam logic [7:0] FSEL_IMPL_MASK = 8'hF3;
  localparam logic [7:0] FSEL_RSVD_ONES = 8'h0C;
  localparam logic [7:0] DIR_READ_VALUE = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Function select bit positions
  localparam int FSEL_TIMER_OUT = 0;
  localparam int FSEL_SERIAL_TX = 1;
  localparam int FSEL_IRQ_LO = 4;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_P1_DIR = 8'h00;
  localparam logic [7:0] RST_P1_DATA = 8'h00;
  localparam logic [7:0] RST_P1_PULLUP = 8'h00;
  localparam logic [2:0] RST_P2_DIR = 3'h0;
  localparam logic [2:0] RST_P2_DATA = 3'h0;
  localparam logic [7:0] RST_FUNC_SEL = 8'h00;

endpackage

// ===== design/pgpio_top.sv
// Purpose: Port 1 / port 2 pin control with alternate functions
// Assumes: Pin inputs synchronous to clk_sys_i, clk_en_i gates all state
// Notes: Pad pull-up is a plain output per port 1 pin
//
// Local design decisions: strobed register access and the address map.

`timescale 1ns/1ps

// How it works
// - Data latch bit drives its pin while pin is general output.
// - Reading data register of an output pin returns the latch.
// - Reading data register of an input pin returns the pin level.
// - Port 1 data and pull-up bit 3 ignore writes, read as one.
// - Port 2 data bits 7..3 ignore writes and read as one.
// - Every usable port 1 pin has its own pull-up enable bit.
// - Pull-up acts only while the pin's direction bit is zero.
// - On an input pin, pull-up bit one means on, zero off.
// - Direction one makes a general pin an output, zero an input.
// - Port 2 direction holds only bits 2..0.
// - Port 2 has only direction and data registers.
// - Selected alternate function owns the pin; direction is ignored for output enable.
// - Serial settings win on port 2; receive enable takes pin one.
// - Port 1 pins 2 and 1 follow only their direction bits.
// - Port 2 pins are general I/O; pins 2 and 1 also routed to the serial unit.
// - Select bits 7..4 make pins 7..4 interrupt inputs; pin 7 trigger.
// - Select bit 1 makes port 2 pin 2 the serial transmit output.
// - Select bit 0 makes port 1 pin 0 timer out; bits 3,2 read one.
module pgpio_top (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] p1_pin_i,
  output logic [7:0] p1_pin_o,
  output logic [7:0] p1_pin_oe_o,
  output logic [7:0] p1_pullup_o,
  input wire logic [2:0] p2_pin_i,
  output logic [2:0] p2_pin_o,
  output logic [2:0] p2_pin_oe_o,
  input wire logic serial_receive_enable_i,
  input wire logic serial_tx_data_i,
  output logic serial_rx_data_o,
  input wire logic timer_wave_out_i,
  output logic [3:0] ext_interrupt_in_o,
  output logic timer_trigger_in_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] p1_dir;
    logic [7:0] p1_data;
    logic [7:0] p1_pullup;
    logic [2:0] p2_dir;
    logic [2:0] p2_data;
    logic [7:0] fsel;
    logic [7:0] rdata;
  } pgpio_state_t;

  pgpio_state_t state_r;
  pgpio_state_t state_nxt;
  logic [7:0] p1_alt;
  logic [7:0] p1_gen_out;
  logic [2:0] p2_gen_out;
  logic [7:0] p1_read;
  logic [2:0] p2_read;

  // ==========================================================
  // Pin ownership
  always_comb begin
    p1_alt = 8'h00;
    p1_alt[7:4] = state_r.fsel[7:4];
    p1_alt[0] = state_r.fsel[pgpio_pkg::FSEL_TIMER_OUT];
    p1_gen_out = state_r.p1_dir & ~p1_alt & pgpio_pkg::P1_IMPL_MASK;
    p2_gen_out = state_r.p2_dir;
    p2_gen_out[2] = state_r.p2_dir[2] & ~state_r.fsel[pgpio_pkg::FSEL_SERIAL_TX];
    p2_gen_out[1] = state_r.p2_dir[1] & ~serial_receive_enable_i;
  end

  // ==========================================================
  // Pad drive
  always_comb begin
    p1_pin_o = state_r.p1_data & p1_gen_out;
    p1_pin_oe_o = p1_gen_out;
    if (state_r.fsel[pgpio_pkg::FSEL_TIMER_OUT]) begin
      p1_pin_o[0] = timer_wave_out_i;
      p1_pin_oe_o[0] = 1'b1;
    end
    // Pull-up only where the direction bit is zero, alternate inputs included
    p1_pullup_o = state_r.p1_pullup & ~state_r.p1_dir & pgpio_pkg::P1_IMPL_MASK;
    p1_pullup_o[0] = p1_pullup_o[0] & ~state_r.fsel[pgpio_pkg::FSEL_TIMER_OUT];
    p2_pin_o = state_r.p2_data & p2_gen_out;
    p2_pin_oe_o = p2_gen_out;
    if (state_r.fsel[pgpio_pkg::FSEL_SERIAL_TX]) begin
      p2_pin_o[2] = serial_tx_data_i;
      p2_pin_oe_o[2] = 1'b1;
    end
  end

  // Alternate inputs see the pin only when selected, idle high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ext_interrupt_in_o[i] = state_r.fsel[pgpio_pkg::FSEL_IRQ_LO + i] ?
        p1_pin_i[pgpio_pkg::FSEL_IRQ_LO + i] : 1'b1;
    end
    timer_trigger_in_o = ext_interrupt_in_o[3];
    serial_rx_data_o = serial_receive_enable_i ? p2_pin_i[1] : 1'b1;
  end

  // ==========================================================
  // Read-back mux
  always_comb begin
    p1_read = (state_r.p1_data & state_r.p1_dir) | (p1_pin_i & ~state_r.p1_dir);
    p2_read = (state_r.p2_data & state_r.p2_dir) | (p2_pin_i & ~state_r.p2_dir);
  end

  // ==========================================================
  // Register update
  always_comb begin
    state_nxt = state_r;
    if (wr_i) begin
      case (addr_i)
        pgpio_pkg::ADDR_P1_DIR: state_nxt.p1_dir = wdata_i & pgpio_pkg::P1_IMPL_MASK;
        pgpio_pkg::ADDR_P1_DATA: state_nxt.p1_data = wdata_i & pgpio_pkg::P1_IMPL_MASK;
        pgpio_pkg::ADDR_P1_PULLUP: state_nxt.p1_pullup = wdata_i & pgpio_pkg::P1_IMPL_MASK;
        pgpio_pkg::ADDR_P2_DIR: state_nxt.p2_dir = wdata_i[2:0] & pgpio_pkg::P2_IMPL_MASK;
        pgpio_pkg::ADDR_P2_DATA: state_nxt.p2_data = wdata_i[2:0];
        pgpio_pkg::ADDR_FUNC_SEL: state_nxt.fsel = wdata_i & pgpio_pkg::FSEL_IMPL_MASK;
        default: state_nxt = state_r;
      endcase
    end
    state_nxt.rdata = pgpio_pkg::UNMAPPED_READ;
    if (rd_i) begin
      case (addr_i)
        pgpio_pkg::ADDR_P1_DIR: state_nxt.rdata = pgpio_pkg::DIR_READ_VALUE;
        pgpio_pkg::ADDR_P1_DATA: state_nxt.rdata = (p1_read & pgpio_pkg::P1_IMPL_MASK) |
          pgpio_pkg::P1_RSVD_ONES;
        pgpio_pkg::ADDR_P1_PULLUP: state_nxt.rdata = state_r.p1_pullup |
          pgpio_pkg::P1_RSVD_ONES;
        pgpio_pkg::ADDR_P2_DIR: state_nxt.rdata = pgpio_pkg::DIR_READ_VALUE;
        pgpio_pkg::ADDR_P2_DATA: state_nxt.rdata = {5'h00, p2_read} |
          pgpio_pkg::P2_RSVD_ONES;
        pgpio_pkg::ADDR_FUNC_SEL: state_nxt.rdata = state_r.fsel |
          pgpio_pkg::FSEL_RSVD_ONES;
        default: state_nxt.rdata = pgpio_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r.p1_dir <= pgpio_pkg::RST_P1_DIR;
      state_r.p1_data <= pgpio_pkg::RST_P1_DATA;
      state_r.p1_pullup <= pgpio_pkg::RST_P1_PULLUP;
      state_r.p2_dir <= pgpio_pkg::RST_P2_DIR;
      state_r.p2_data <= pgpio_pkg::RST_P2_DATA;
      state_r.fsel <= pgpio_pkg::RST_FUNC_SEL;
      state_r.rdata <= pgpio_pkg::UNMAPPED_READ;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o = state_r.rdata;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_p1_out_drive: assert property (
    (p1_pin_oe_o[2] |-> p1_pin_o[2] == state_r.p1_data[2]))
    else $error("port 1 pin 2 not driven from latch");
  a_out_readback: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_DATA && state_r.p1_dir[1]
     && !(wr_i)) |=> rdata_o[1] == $past(state_r.p1_data[1]))
    else $error("output pin read not latch");
  a_in_readback: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P2_DATA && !state_r.p2_dir[0])
    |=> rdata_o[0] == $past(p2_pin_i[0]))
    else $error("input pin read not pin level");
  a_rsvd_ones: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P2_DATA) |=> rdata_o[7:3] == 5'h1F)
    else $error("port 2 reserved bits not one");
  a_bit3_ones: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_PULLUP) |=> rdata_o[3])
    else $error("port 1 pull-up bit 3 not one");
  a_pullup_gate: assert property (
    state_r.p1_dir[5] |-> !p1_pullup_o[5])
    else $error("pull-up on for output pin");
  a_alt_owns: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_FUNC_SEL && wdata_i[6])
    |=> !p1_pin_oe_o[6] && ext_interrupt_in_o[2] == p1_pin_i[6])
    else $error("alternate input did not take pin");
  a_tx_route: assert property (
    state_r.fsel[1] |-> p2_pin_oe_o[2] && p2_pin_o[2] == serial_tx_data_i)
    else $error("serial transmit not on pin");
  a_rx_route: assert property (
    serial_receive_enable_i |-> !p2_pin_oe_o[1] && serial_rx_data_o == p2_pin_i[1])
    else $error("serial receive not on pin");
  a_dir_readall: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P2_DIR) |=> rdata_o == 8'hFF)
    else $error("direction read not all ones");

  // ==========================================================
  // Register file checks
  // Enable low must hold every bit, read data included
  a_freeze_state: assert property (
    (!clk_en_i) |=> state_r == $past(state_r))
    else $error("state moved while clock enable low");
  a_idle_rdata: assert property (
    (clk_en_i && !rd_i) |=> rdata_o == pgpio_pkg::UNMAPPED_READ)
    else $error("read data not cleared after read");
  a_p1_dir_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_P1_DIR)
    |=> state_r.p1_dir == ($past(wdata_i) & pgpio_pkg::P1_IMPL_MASK))
    else $error("port 1 direction write lost");
  a_p1_data_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_P1_DATA)
    |=> state_r.p1_data == ($past(wdata_i) & pgpio_pkg::P1_IMPL_MASK))
    else $error("port 1 data write lost");
  a_pullup_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_P1_PULLUP)
    |=> state_r.p1_pullup == ($past(wdata_i) & pgpio_pkg::P1_IMPL_MASK))
    else $error("port 1 pull-up write lost");
  a_p2_dir_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_P2_DIR)
    |=> state_r.p2_dir == $past(wdata_i[2:0]))
    else $error("port 2 direction write lost");
  a_p2_data_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_P2_DATA)
    |=> state_r.p2_data == $past(wdata_i[2:0]))
    else $error("port 2 data write lost");
  a_fsel_write: assert property (
    (clk_en_i && wr_i && addr_i == pgpio_pkg::ADDR_FUNC_SEL)
    |=> state_r.fsel == ($past(wdata_i) & pgpio_pkg::FSEL_IMPL_MASK))
    else $error("function select write lost");
  a_bit3_empty: assert property (
    !state_r.p1_data[3] && !state_r.p1_pullup[3])
    else $error("reserved bit 3 took a write");
  a_p1_rdata_bit3: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_DATA) |=> rdata_o[3])
    else $error("port 1 data bit 3 not one");
  a_fsel_rsvd: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_FUNC_SEL) |=> rdata_o[3:2] == 2'h3)
    else $error("select reserved bits not one");
  a_fsel_rdata: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_FUNC_SEL)
    |=> rdata_o == ($past(state_r.fsel) | pgpio_pkg::FSEL_RSVD_ONES))
    else $error("select read-back wrong");
  a_pullup_rdata: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_PULLUP)
    |=> rdata_o == ($past(state_r.p1_pullup) | pgpio_pkg::P1_RSVD_ONES))
    else $error("pull-up read-back wrong");
  a_p1dir_read: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_DIR) |=> rdata_o == 8'hFF)
    else $error("port 1 direction read not all ones");
  a_p2_out_read: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P2_DATA && state_r.p2_dir[2])
    |=> rdata_o[2] == $past(state_r.p2_data[2]))
    else $error("port 2 output read not latch");
  a_p1_in_read: assert property (
    (clk_en_i && rd_i && addr_i == pgpio_pkg::ADDR_P1_DATA && !state_r.p1_dir[7])
    |=> rdata_o[7] == $past(p1_pin_i[7]))
    else $error("port 1 input read not pin level");
  a_unmapped_read: assert property (
    (clk_en_i && rd_i && addr_i > pgpio_pkg::ADDR_FUNC_SEL) |=> rdata_o == 8'h00)
    else $error("unmapped index did not read zero");

  // ==========================================================
  // Pin checks
  // Bit 3 has no pad behind it, so it must never drive or pull
  a_bit3_float: assert property (
    !p1_pin_oe_o[3] && !p1_pullup_o[3])
    else $error("bit 3 pad driven or pulled");
  a_gen_output: assert property (
    (!state_r.fsel[4] && state_r.p1_dir[4])
    |-> p1_pin_oe_o[4] && p1_pin_o[4] == state_r.p1_data[4])
    else $error("general output pin not driven");
  a_gen_input: assert property (
    !state_r.p1_dir[1] |-> !p1_pin_oe_o[1])
    else $error("general input pin driven");
  a_plain_pins: assert property (
    p1_pin_oe_o[2:1] == state_r.p1_dir[2:1])
    else $error("plain pins not following direction");
  a_pullup_input: assert property (
    !state_r.p1_dir[6] |-> p1_pullup_o[6] == state_r.p1_pullup[6])
    else $error("input pull-up not per enable bit");
  a_irq_idle: assert property (
    !state_r.fsel[4] |-> ext_interrupt_in_o[0])
    else $error("unselected interrupt input not idle");
  a_irq_route: assert property (
    state_r.fsel[7] |-> ext_interrupt_in_o[3] == p1_pin_i[7] && timer_trigger_in_o == p1_pin_i[7])
    else $error("pin 7 not routed to interrupt and trigger");
  a_timer_out: assert property (
    state_r.fsel[0] |-> p1_pin_oe_o[0] && p1_pin_o[0] == timer_wave_out_i && !p1_pullup_o[0])
    else $error("timer output not on pin 0");
  a_p2_gen_drive: assert property (
    (!state_r.fsel[1] && state_r.p2_dir[2])
    |-> p2_pin_oe_o[2] && p2_pin_o[2] == state_r.p2_data[2])
    else $error("port 2 general output not driven");
  a_p2_gen_input: assert property (
    (!state_r.fsel[1] && !state_r.p2_dir[2]) |-> !p2_pin_oe_o[2])
    else $error("port 2 general input driven");
  a_p2_pin_zero: assert property (
    p2_pin_oe_o[0] == state_r.p2_dir[0])
    else $error("port 2 pin 0 not per direction");
  a_rx_idle: assert property (
    !serial_receive_enable_i |-> serial_rx_data_o)
    else $error("serial receive not idle high");

  c_timer_out: cover property (state_r.fsel[0] && p1_pin_oe_o[0]);
  c_p1_output: cover property (p1_pin_oe_o[7] && p1_pin_o[7]);
  c_pullup_on: cover property (p1_pullup_o[2]);
  c_rx_sel: cover property (serial_receive_enable_i && p2_pin_i[1]);
  c_frozen_wr: cover property (!clk_en_i && wr_i);

endmodule

// ===== sim/pgpio_board.sv
// Purpose: Board-side model of the port 1 and port 2 pads
// Assumes: Pads driven by the block win over the board
// Notes: Undriven, unpulled pads toggle while board drive is off, so stale values never pass
`timescale 1ns/1ps
module pgpio_board (
  input wire logic clk_sys_i,
  input wire logic ext_en_i,
  input wire logic [7:0] ext_p1_i,
  input wire logic [2:0] ext_p2_i,
  input wire logic [7:0] p1_o_i,
  input wire logic [7:0] p1_oe_i,
  input wire logic [7:0] p1_pu_i,
  input wire logic [2:0] p2_o_i,
  input wire logic [2:0] p2_oe_i,
  output logic [7:0] p1_lvl_o,
  output logic [2:0] p2_lvl_o
);
  logic flt_r = 1'b0;
  always @(posedge clk_sys_i) flt_r <= ~flt_r;
  // =====================================
  // Pad resolution
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p1_lvl_o[i] = p1_oe_i[i] ? p1_o_i[i] : ext_en_i ? ext_p1_i[i] :
                    p1_pu_i[i] ? 1'b1 : flt_r;
    end
    for (int i = 0; i < 3; i++) begin
      p2_lvl_o[i] = p2_oe_i[i] ? p2_o_i[i] : ext_en_i ? ext_p2_i[i] : flt_r;
    end
  end
endmodule

// ===== sim/pgpio_top_test.sv
// Purpose: Self-checking bench for the two-port general I/O block
// Assumes: Board drives A5 on port 1 and 6 on port 2 when enabled
// Notes: Tasks end at the falling edge so checks see settled values
`timescale 1ns/1ps
module pgpio_top_test;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, p1_pin_i, p1_pin_o, p1_pin_oe_o, p1_pullup_o;
  logic [2:0] p2_pin_i, p2_pin_o, p2_pin_oe_o;
  logic rxen = 1'b0;
  logic txd = 1'b0;
  logic tmr = 1'b0;
  logic ext_en = 1'b1;
  logic clk_en = 1'b1;
  logic rxd, trg;
  logic [3:0] irq;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  pgpio_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o),
    .p1_pullup_o(p1_pullup_o), .p2_pin_i(p2_pin_i), .p2_pin_o(p2_pin_o),
    .p2_pin_oe_o(p2_pin_oe_o), .serial_receive_enable_i(rxen), .serial_tx_data_i(txd),
    .serial_rx_data_o(rxd), .timer_wave_out_i(tmr), .ext_interrupt_in_o(irq),
    .timer_trigger_in_o(trg));
  pgpio_board board (.clk_sys_i(clk_sys_i), .ext_en_i(ext_en), .ext_p1_i(8'hA5),
    .ext_p2_i(3'h6), .p1_o_i(p1_pin_o), .p1_oe_i(p1_pin_oe_o), .p1_pu_i(p1_pullup_o),
    .p2_o_i(p2_pin_o), .p2_oe_i(p2_pin_oe_o), .p1_lvl_o(p1_pin_i), .p2_lvl_o(p2_pin_i));
  // =====================================
  // Bus tasks and comparison
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_sys_i) wr_i <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_sys_i) rd_i <= 1'b0;
    @(negedge clk_sys_i) chk(rdata_o, exp);
  endtask
  task automatic stop_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 70 cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end
  // =====================================
  // Scenarios
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rd(pgpio_pkg::ADDR_P1_DATA, 8'hAD);
    rd(pgpio_pkg::ADDR_P1_DIR, 8'hFF);
    rd(pgpio_pkg::ADDR_P1_PULLUP, 8'h08);
    rd(pgpio_pkg::ADDR_P2_DATA, 8'hFE);
    rd(pgpio_pkg::ADDR_P2_DIR, 8'hFF);
    rd(pgpio_pkg::ADDR_FUNC_SEL, 8'h0C);
    rd(4'hA, 8'h00);
    chk(p1_pin_oe_o, 8'h00);
    wr(pgpio_pkg::ADDR_P1_DIR, 8'hFF);
    wr(pgpio_pkg::ADDR_P1_DATA, 8'h5A);
    chk(p1_pin_o, 8'h52);
    chk(p1_pin_oe_o, 8'hF7);
    rd(pgpio_pkg::ADDR_P1_DATA, 8'h5A);
    wr(pgpio_pkg::ADDR_P1_PULLUP, 8'hFF);
    chk(p1_pullup_o, 8'h00);
    wr(pgpio_pkg::ADDR_P1_DIR, 8'h0F);
    chk(p1_pullup_o, 8'hF0);
    rd(pgpio_pkg::ADDR_P1_PULLUP, 8'hFF);
    @(posedge clk_sys_i) ext_en <= 1'b0;
    wr(pgpio_pkg::ADDR_P1_DIR, 8'h00);
    chk(p1_pullup_o, 8'hF7);
    rd(pgpio_pkg::ADDR_P1_DATA, 8'hFF);
    wr(pgpio_pkg::ADDR_P1_PULLUP, 8'h12);
    chk(p1_pullup_o, 8'h12);
    @(posedge clk_sys_i) ext_en <= 1'b1;
    wr(pgpio_pkg::ADDR_P2_DIR, 8'hF5);
    wr(pgpio_pkg::ADDR_P2_DATA, 8'h01);
    chk({p2_pin_oe_o, 2'h0, p2_pin_o}, {3'h5, 2'h0, 3'h1});
    rd(pgpio_pkg::ADDR_P2_DATA, 8'hFB);
    wr(pgpio_pkg::ADDR_P2_DIR, 8'h07);
    @(posedge clk_sys_i) rxen <= 1'b1;
    @(negedge clk_sys_i) chk({5'h0, p2_pin_oe_o[1], rxd}, 8'h01);
    wr(pgpio_pkg::ADDR_P1_DIR, 8'hFF);
    wr(pgpio_pkg::ADDR_FUNC_SEL, 8'hFF);
    rd(pgpio_pkg::ADDR_FUNC_SEL, 8'hFF);
    chk(p1_pin_oe_o, 8'h07);
    chk({3'h0, irq, trg}, 8'h15);
    @(posedge clk_sys_i) {tmr, txd} <= 2'b11;
    @(negedge clk_sys_i) chk({6'h00, p1_pin_o[0], p2_pin_o[2]}, 8'h03);
    @(posedge clk_sys_i) {tmr, txd} <= 2'b00;
    @(negedge clk_sys_i) chk({5'h00, p1_pin_o[0], p2_pin_o[2], p2_pin_oe_o[2]}, 8'h01);
    // Write while enable is low must be lost
    @(posedge clk_sys_i) clk_en <= 1'b0;
    wr(pgpio_pkg::ADDR_P1_DATA, 8'h00);
    @(posedge clk_sys_i) clk_en <= 1'b1;
    rd(pgpio_pkg::ADDR_P1_DATA, 8'h5A);
    @(posedge clk_sys_i) reset_n_i <= 1'b0;
    @(posedge clk_sys_i) reset_n_i <= 1'b1;
    rd(pgpio_pkg::ADDR_P1_DATA, 8'hAD);
    rd(pgpio_pkg::ADDR_P1_PULLUP, 8'h08);
    chk(p1_pin_oe_o, 8'h00);
    chk({5'h00, p2_pin_oe_o}, 8'h00);
    stop_test();
  end
endmodule
